// >>> hw/i2c_page_pkg.sv
package i2c_page_pkg;

  // ----------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR      = 7'h30;   // 0110000
  localparam logic [2:0] ADDR_HI_IDX   = 3'h0;    // Write byte index, reg addr [15:8]
  localparam logic [2:0] ADDR_LO_IDX   = 3'h1;    // Write byte index, reg addr [7:0]
  localparam logic [2:0] LAST_DATA_IDX = 3'h5;    // Write byte index, data [31:24]
  localparam logic [2:0] RD_LAST_IDX   = 3'h3;    // Read byte index, data [31:24]

  // ----------------------------------------------------------------
  // Bit framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_ACK  = 4'h8;         // Eight bits in, ack slot next
  localparam logic [3:0] BIT_DONE = 4'h9;         // Ack bit clocked

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 10_000_000;
  localparam int SCL_MAX_HZ  = 400_000;
  // Quarter of a serial bit, rounded up so the rate never exceeds the limit
  localparam int QUARTER_CYC = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);

  // ----------------------------------------------------------------
  // Byte engine commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} cmd_t;

endpackage : i2c_page_pkg

// >>> hw/i2c_link_if.sv
`timescale 1ns/100ps
interface i2c_link_if;

  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up: a line is low while any enabled driver pulls it
  assign scl = (host_scl_out | ~host_scl_oe) & (dev_scl_out | ~dev_scl_oe);
  assign sda = (host_sda_out | ~host_sda_oe) & (dev_sda_out | ~dev_sda_oe);

  modport host (
    output host_scl_out,
    output host_scl_oe,
    output host_sda_out,
    output host_sda_oe,
    input  scl,
    input  sda
  );

  modport device (
    output dev_scl_out,
    output dev_scl_oe,
    output dev_sda_out,
    output dev_sda_oe,
    input  scl,
    input  sda
  );

endinterface : i2c_link_if

// >>> hw/i2c_byte_master.sv
`timescale 1ns/100ps
module i2c_byte_master #(
  parameter int QUARTER = i2c_page_pkg::QUARTER_CYC
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               cmd_valid,
  input  wire i2c_page_pkg::cmd_t cmd,
  input  wire logic [7:0]         wdata,
  input  wire logic               ack_send,
  input  wire logic               sda_in,
  output logic                    cmd_ready,
  output logic                    done,
  output logic [7:0]              rdata,
  output logic                    ack_seen,
  output logic                    scl_pull,
  output logic                    sda_pull
);
  import i2c_page_pkg::*;

  // Sampling at the end of the third quarter needs the synchroniser settled
  if (QUARTER < 3 || QUARTER > 255) begin : g_check
    $error("i2c_byte_master: QUARTER out of range");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_STOP, ST_BIT} eng_t;

  eng_t       state;
  logic [7:0] cnt;
  logic [1:0] q;
  logic [3:0] bitn;
  logic [8:0] shreg;
  logic       sda_m;
  logic       sda_s;

  // ----------------------------------------------------------------
  // Phase decode
  // ----------------------------------------------------------------
  wire tick          = (cnt == 8'(QUARTER - 1));
  wire last_q        = tick && (q == 2'h3);
  wire sample_now    = tick && (q == 2'h2) && (state == ST_BIT);
  // Clock low in the first and last quarter (first only for a stop); data bits move only while low
  wire next_scl_pull = (state == ST_STOP) ? (q == 2'h0) : (q == 2'h0 || q == 2'h3);
  wire next_sda_pull = (state == ST_START) ? (q >= 2'h2) :
                       (state == ST_STOP)  ? (q <= 2'h1) :
                       (q == 2'h0) ? ~shreg[8] : sda_pull;

  // Data line synchroniser
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= sda_in;
      sda_s <= sda_m;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      cnt       <= 8'h00;
      q         <= 2'h0;
      bitn      <= 4'h0;
      shreg     <= 9'h1ff;
      cmd_ready <= 1'b1;
      done      <= 1'b0;
      rdata     <= 8'h00;
      ack_seen  <= 1'b0;
      scl_pull  <= 1'b0;
      sda_pull  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (state == ST_IDLE) begin
        cnt <= 8'h00;
        q   <= 2'h0;
        if (cmd_valid) begin
          state     <= (cmd == CMD_START) ? ST_START : (cmd == CMD_STOP) ? ST_STOP : ST_BIT;
          // Read bytes release the line and end with our own ack level
          shreg     <= (cmd == CMD_READ) ? {8'hff, ~ack_send} : {wdata, 1'b1};
          bitn      <= 4'h0;
          cmd_ready <= 1'b0;
        end
      end else begin
        scl_pull <= next_scl_pull;
        sda_pull <= next_sda_pull;
        cnt      <= tick ? 8'h00 : cnt + 8'h01;
        if (tick) begin
          q <= q + 2'h1;
        end
        if (sample_now && bitn != BIT_ACK) begin
          rdata <= {rdata[6:0], sda_s};
        end else if (sample_now) begin
          ack_seen <= ~sda_s;
        end
        if (last_q && state == ST_BIT && bitn != BIT_ACK) begin
          bitn  <= bitn + 4'h1;
          shreg <= {shreg[7:0], 1'b1};
        end else if (last_q) begin
          state     <= ST_IDLE;
          done      <= 1'b1;
          cmd_ready <= 1'b1;
        end
      end
    end
  end

endmodule : i2c_byte_master

// >>> hw/i2c_page_host.sv
`timescale 1ns/100ps
module i2c_page_host #(
  parameter int QUARTER = i2c_page_pkg::QUARTER_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  i2c_link_if.host         link,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             req_ready,
  output logic             resp_valid,
  output logic [31:0]      resp_rdata,
  output logic             resp_nack
);
  import i2c_page_pkg::*;

  logic [3:0]  step;
  logic        wr;
  logic        busy;
  logic        issued;
  logic [15:0] addr;
  logic [31:0] wdat;
  logic        cmd_valid;
  logic        eng_ready;
  logic        eng_done;
  logic [7:0]  eng_rdata;
  logic        eng_ack;

  // ----------------------------------------------------------------
  // Step tables
  // ----------------------------------------------------------------
  // Write: start, addr, reg hi, reg lo, d0..d3, stop; read: restart, addr, r0..r3 after reg lo
  function automatic cmd_t step_kind(input logic [3:0] s, input logic w);
    if (s == 4'h0 || (!w && s == 4'h4)) return CMD_START;
    else if ((w && s == 4'h8) || (!w && s == 4'ha)) return CMD_STOP;
    else if (!w && s >= 4'h6) return CMD_READ;
    else return CMD_WRITE;
  endfunction : step_kind

  function automatic logic [7:0] step_byte(input logic [3:0] s, input logic w,
                                           input logic [15:0] a, input logic [31:0] d);
    if (s == 4'h1) return {DEV_ADDR, 1'b0};
    else if (s == 4'h2) return a[15:8];
    else if (s == 4'h3) return a[7:0];
    else if (!w) return {DEV_ADDR, 1'b1};
    else return d[8 * (s - 4'h4) +: 8];
  endfunction : step_byte

  wire cmd_t       kind      = step_kind(step, wr);
  wire logic [7:0] byte_out  = step_byte(step, wr, addr, wdat);
  wire logic [3:0] stop_step = wr ? 4'h8 : 4'ha;

  // Byte engine for the link pins
  i2c_byte_master #(.QUARTER(QUARTER)) u_engine (
    .clk       (clk),
    .reset_n   (reset_n),
    .cmd_valid (cmd_valid),
    .cmd       (kind),
    .wdata     (byte_out),
    .ack_send  (1'b1),
    .sda_in    (link.sda),
    .cmd_ready (eng_ready),
    .done      (eng_done),
    .rdata     (eng_rdata),
    .ack_seen  (eng_ack),
    .scl_pull  (link.host_scl_oe),
    .sda_pull  (link.host_sda_oe)
  );

  // Open drain: only ever pull low
  assign link.host_scl_out = 1'b0;
  assign link.host_sda_out = 1'b0;

  // ----------------------------------------------------------------
  // Transfer control
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      step       <= 4'h0;
      wr         <= 1'b0;
      busy       <= 1'b0;
      issued     <= 1'b0;
      addr       <= 16'h0000;
      wdat       <= 32'h0000_0000;
      cmd_valid  <= 1'b0;
      req_ready  <= 1'b1;
      resp_valid <= 1'b0;
      resp_rdata <= 32'h0000_0000;
      resp_nack  <= 1'b0;
    end else begin
      cmd_valid  <= 1'b0;
      resp_valid <= 1'b0;
      if (!busy && req_valid) begin
        busy      <= 1'b1;
        req_ready <= 1'b0;
        wr        <= req_write;
        addr      <= req_addr;
        wdat      <= req_wdata;
        step      <= 4'h0;
        resp_nack <= 1'b0;
      end else if (busy && !issued && eng_ready) begin
        cmd_valid <= 1'b1;
        issued    <= 1'b1;
      end else if (eng_done) begin
        issued <= 1'b0;
        if (kind == CMD_STOP) begin
          busy       <= 1'b0;
          req_ready  <= 1'b1;
          resp_valid <= 1'b1;
        end else if (kind == CMD_WRITE && !eng_ack) begin
          // Missing acknowledge: abandon with a stop
          resp_nack <= 1'b1;
          step      <= stop_step;
        end else begin
          if (kind == CMD_READ) begin
            resp_rdata <= {eng_rdata, resp_rdata[31:8]};
          end
          step <= step + 4'h1;
        end
      end
    end
  end

endmodule : i2c_page_host

// >>> hw/i2c_page_device.sv
`timescale 1ns/100ps
// Contract
// - Serial clock at most 400 kHz
// - Both lines open drain, pull low only
// - Data steady while clock high
// - Transfers framed by START and STOP
// - START is data falling, clock high
// - Write is seven bytes total
// - Each byte followed by acknowledge low
// - Single data byte commands are ignored
// - Answer only bus address 0110000
// - Address sent MSB first, zero writes
// - Bits sampled on clock rising edge
// - Acknowledge address only when it matches
// - Register address high then low, acknowledged
// - Data low byte first, MSB first
// - STOP after last data acknowledge
// - Device can also act as master
// - Read: address, restart, four bytes returned
module i2c_page_device #(
  parameter int QUARTER = i2c_page_pkg::QUARTER_CYC
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  i2c_link_if.device              link,
  output logic [15:0]             reg_addr,
  output logic                    reg_wr_valid,
  output logic [31:0]             reg_wr_data,
  output logic                    reg_rd_strobe,
  input  wire logic [31:0]        reg_rd_data,
  input  wire logic               mst_cmd_valid,
  input  wire i2c_page_pkg::cmd_t mst_cmd,
  input  wire logic [7:0]         mst_wdata,
  input  wire logic               mst_ack_send,
  output logic                    mst_ready,
  output logic                    mst_done,
  output logic [7:0]              mst_rdata,
  output logic                    mst_ack_seen
);
  import i2c_page_pkg::*;

  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_WRITE, SL_READ, SL_IGNORE} slave_t;

  slave_t      state;
  slave_t      next_state;
  logic [1:0]  scl_sy;
  logic [1:0]  sda_sy;
  logic        scl_d;
  logic        sda_d;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic [2:0]  bytecnt;
  logic        acked;
  logic        line_ack;
  logic        addr_ok;
  logic [7:0]  addr_hi;
  logic [31:0] wbuf;
  logic [31:0] txbuf;
  logic        sda_pull_s;
  logic        mst_scl_pull;
  logic        mst_sda_pull;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // Serial clock comes from the far end, so both lines are resampled
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_sy <= 2'b11;
      sda_sy <= 2'b11;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], link.scl};
      sda_sy <= {sda_sy[0], link.sda};
      scl_d  <= scl_sy[1];
      sda_d  <= sda_sy[1];
    end
  end

  wire scl_s      = scl_sy[1];
  wire sda_s      = sda_sy[1];
  wire scl_rise   = scl_s & ~scl_d;
  wire scl_fall   = ~scl_s & scl_d;
  wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Byte framing decode
  // ----------------------------------------------------------------
  wire       ack_slot_in  = scl_fall && (bitcnt == BIT_ACK);
  wire       ack_slot_out = scl_fall && (bitcnt == BIT_DONE);
  wire       rw_bit       = shreg[0];
  wire       addr_match   = (shreg[7:1] == DEV_ADDR);
  // A read needs a full register address earlier in the same transfer
  wire       ack_addr     = addr_match && (!rw_bit || addr_ok);
  // Bytes past the seventh are refused
  wire       ack_write    = (bytecnt <= LAST_DATA_IDX);
  wire       give_ack     = (state == SL_ADDR && ack_addr) ||
                            (state == SL_WRITE && ack_write);
  wire [2:0] tx_idx       = 3'h7 - bitcnt[2:0];
  wire       tx_bit_fall  = scl_fall && (state == SL_READ) &&
                            (bitcnt != 4'h0) && (bitcnt < BIT_ACK);
  wire       next_tx7     = (state == SL_ADDR) ? txbuf[7] : txbuf[15];

  // Where the transfer goes when an ack slot ends
  always_comb begin
    case (state)
      SL_ADDR:  next_state = !acked ? SL_IGNORE : (rw_bit ? SL_READ : SL_WRITE);
      SL_WRITE: next_state = acked ? SL_WRITE : SL_IGNORE;
      // Master nack or last byte ends our driving
      SL_READ:  next_state = (line_ack && bytecnt != RD_LAST_IDX) ? SL_READ : SL_IGNORE;
      default:  next_state = state;
    endcase
  end

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state    <= SL_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      bytecnt  <= 3'h0;
      acked    <= 1'b0;
      line_ack <= 1'b0;
      addr_ok  <= 1'b0;
    end else if (start_seen) begin
      // Repeated start keeps the register address
      state   <= SL_ADDR;
      bitcnt  <= 4'h0;
      bytecnt <= 3'h0;
    end else if (stop_seen) begin
      state   <= SL_IDLE;
      addr_ok <= 1'b0;
    end else if (state != SL_IDLE && state != SL_IGNORE) begin
      if (scl_rise && bitcnt < BIT_ACK) begin
        shreg <= {shreg[6:0], sda_s};
      end
      if (scl_rise && bitcnt != BIT_DONE) begin
        bitcnt <= bitcnt + 4'h1;
      end
      if (scl_rise && bitcnt == BIT_ACK) begin
        line_ack <= ~sda_s;
      end
      if (ack_slot_in) begin
        acked <= give_ack;
      end
      if (ack_slot_out) begin
        bitcnt  <= 4'h0;
        state   <= next_state;
        bytecnt <= (state == SL_ADDR) ? 3'h0 : bytecnt + 3'h1;
        if (state == SL_WRITE && acked && bytecnt == ADDR_LO_IDX) begin
          addr_ok <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register address, write data and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_hi       <= 8'h00;
      reg_addr      <= 16'h0000;
      wbuf          <= 32'h0000_0000;
      txbuf         <= 32'h0000_0000;
      reg_wr_valid  <= 1'b0;
      reg_wr_data   <= 32'h0000_0000;
      reg_rd_strobe <= 1'b0;
    end else begin
      reg_wr_valid  <= 1'b0;
      reg_rd_strobe <= 1'b0;
      if (ack_slot_in && state == SL_ADDR && ack_addr && rw_bit) begin
        txbuf         <= reg_rd_data;
        reg_rd_strobe <= 1'b1;
      end
      if (ack_slot_out && state == SL_READ) begin
        txbuf <= {8'h00, txbuf[31:8]};
      end
      if (ack_slot_out && state == SL_WRITE && acked) begin
        if (bytecnt == ADDR_HI_IDX) begin
          addr_hi <= shreg;
        end else if (bytecnt == ADDR_LO_IDX) begin
          reg_addr <= {addr_hi, shreg};
        end else begin
          wbuf <= {shreg, wbuf[31:8]};
        end
        // Short transfers never reach here, so the target stays untouched
        if (bytecnt == LAST_DATA_IDX) begin
          reg_wr_valid <= 1'b1;
          reg_wr_data  <= {shreg, wbuf[31:8]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Slave data line drive
  // ----------------------------------------------------------------
  // Changes follow the synchronised falling edge, well inside clock low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sda_pull_s <= 1'b0;
    end else if (start_seen || stop_seen || state == SL_IGNORE) begin
      sda_pull_s <= 1'b0;
    end else if (ack_slot_in) begin
      sda_pull_s <= give_ack;
    end else if (ack_slot_out) begin
      sda_pull_s <= (next_state == SL_READ) && ~next_tx7;
    end else if (tx_bit_fall) begin
      sda_pull_s <= ~txbuf[tx_idx];
    end
  end

  // ----------------------------------------------------------------
  // Master role
  // ----------------------------------------------------------------
  i2c_byte_master #(.QUARTER(QUARTER)) u_master (
    .clk       (clk),
    .reset_n   (reset_n),
    .cmd_valid (mst_cmd_valid),
    .cmd       (mst_cmd),
    .wdata     (mst_wdata),
    .ack_send  (mst_ack_send),
    .sda_in    (link.sda),
    .cmd_ready (mst_ready),
    .done      (mst_done),
    .rdata     (mst_rdata),
    .ack_seen  (mst_ack_seen),
    .scl_pull  (mst_scl_pull),
    .sda_pull  (mst_sda_pull)
  );

  // Data pin driver merges both roles, clock pin is master role only; one cycle later but glitch free
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link.dev_scl_oe  <= 1'b0;
      link.dev_sda_oe  <= 1'b0;
      link.dev_scl_out <= 1'b0;
      link.dev_sda_out <= 1'b0;
    end else begin
      link.dev_scl_oe  <= mst_scl_pull;
      link.dev_sda_oe  <= sda_pull_s | mst_sda_pull;
      link.dev_scl_out <= 1'b0;
      link.dev_sda_out <= 1'b0;
    end
  end

endmodule : i2c_page_device

// >>> verification/i2c_page_mode_register_port_checker.sv
`timescale 1ns/100ps
module i2c_page_mode_register_port_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_scl_out,
  input wire logic host_scl_oe,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_scl_out,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ------------
  // Link checks
  // ------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic       scl_q;
  logic [7:0] since_rise;

  // Cycles since last clock rise; saturates so long idle never wraps
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_q      <= 1'b1;
      since_rise <= 8'hff;
    end else begin
      scl_q <= scl;
      if (scl && !scl_q) since_rise <= 8'h00;
      else if (since_rise != 8'hff) since_rise <= since_rise + 8'h01;
    end
  end

  // Open drain, timing and framing relations
  property p_host_od; !(host_scl_out || host_sda_out); endproperty
  a_host_od: assert property (p_host_od) else $error("host drove high");
  property p_dev_od; !(dev_scl_out || dev_sda_out); endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drove high");
  property p_rst_idle; $rose(reset_n) |-> !(host_scl_oe || host_sda_oe || dev_sda_oe); endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("line held after reset");
  property p_period; scl && !scl_q |-> since_rise >= 8'h18; endproperty
  a_period: assert property (p_period) else $error("clock too fast");
  property p_high; $rose(scl) |-> scl [*6]; endproperty
  a_high: assert property (p_high) else $error("clock high too short");
  property p_steady; $changed(dev_sda_oe) && scl |-> !host_scl_oe && !host_sda_oe; endproperty
  a_steady: assert property (p_steady) else $error("device data moved in high");
  property p_ack_hold; $rose(dev_sda_oe) |-> dev_sda_oe [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("pull too short");
  property p_start; $fell(sda) && scl |-> scl [*6]; endproperty
  a_start: assert property (p_start) else $error("start hold short");
  property p_stop; $rose(sda) && scl |-> $past(scl, 6) && $past(scl, 3); endproperty
  a_stop: assert property (p_stop) else $error("stop setup short");

  // Main activity seen
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
  c_ack: cover property ($rose(dev_sda_oe) && !dev_scl_oe);
  c_mst: cover property ($rose(dev_scl_oe));
endmodule : i2c_page_mode_register_port_checker

// >>> verification/i2c_page_mode_register_port_tb.sv
`timescale 1ns/100ps
module i2c_page_mode_register_port_tb;
  import i2c_page_pkg::*;
  // ------------
  // Bench
  // ------------
  logic        clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000, reg_addr, wr_addr;
  logic [31:0] req_wdata = 32'h0, resp_rdata, reg_wr_data, reg_rd_data, wr_data;
  logic        req_ready, resp_valid, resp_nack, reg_wr_valid, mst_cmd_valid = 1'b0;
  logic        mst_ready, mst_done, mst_ack_seen, reg_rd_strobe;
  logic [7:0]  mst_wdata = 8'h00, mst_rdata, wb[$];
  logic [8:0]  sh;
  logic        wa[$];
  cmd_t        mst_cmd = CMD_START;
  int          failures = 0, samples_checked = 0, wr_count = 0, nb = 0, rd_count = 0;

  always #50 clk = ~clk;
  // Register contents derived from address, so reads are predictable
  assign reg_rd_data = {~reg_addr, reg_addr};

  i2c_link_if link();
  i2c_page_host i2c_page_host_inst (.clk, .reset_n, .link(link.host), .req_valid,
    .req_write, .req_addr, .req_wdata, .req_ready, .resp_valid, .resp_rdata, .resp_nack);
  i2c_page_device i2c_page_device_inst (.clk, .reset_n, .link(link.device), .reg_addr,
    .reg_wr_valid, .reg_wr_data, .reg_rd_strobe, .reg_rd_data, .mst_cmd_valid, .mst_cmd,
    .mst_wdata, .mst_ack_send(1'b1), .mst_ready, .mst_done, .mst_rdata, .mst_ack_seen);
  i2c_page_mode_register_port_checker i2c_page_mode_register_port_checker_inst (.clk,
    .reset_n, .host_scl_out(link.host_scl_out), .host_scl_oe(link.host_scl_oe),
    .host_sda_out(link.host_sda_out), .host_sda_oe(link.host_sda_oe),
    .dev_scl_out(link.dev_scl_out), .dev_scl_oe(link.dev_scl_oe),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe),
    .scl(link.scl), .sda(link.sda));

  // Commit capture on the falling clock, clear of the launching edge
  always @(negedge clk) if (reg_wr_valid === 1'b1) begin
    wr_count++;
    wr_addr = reg_addr;
    wr_data = reg_wr_data;
  end
  // Read strobes counted, so a refused read can be told from a taken one
  always @(negedge clk) if (reg_rd_strobe === 1'b1) rd_count++;
  // Wire monitor: START restarts the bit count, ninth bit is the ack
  always @(negedge link.sda) if (link.scl === 1'b1) nb = 0;
  always @(posedge link.scl) begin
    sh = {sh[7:0], link.sda};
    nb++;
    if (nb == 9) begin
      wb.push_back(sh[8:1]);
      wa.push_back(sh[0]);
      nb = 0;
    end
  end

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wire_is(input logic [7:0] e[$]);
    check("byte_count", wb.size(), e.size());
    foreach (e[i]) begin
      check("wire_byte", wb[i], e[i]);
      check("wire_ack", wa[i], 1'b0);
    end
    wb.delete();
    wa.delete();
  endtask : wire_is
  // Request is taken at the next edge because the host is idle
  task automatic host_req(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    step;
    req_valid = 1'b0;
    for (n = 0; n < 5000 && resp_valid !== 1'b1; n++) step;
    check("resp_valid", resp_valid, 1'b1);
    check("req_ready", req_ready, 1'b1);
  endtask : host_req
  // Leading step lets the previous done pulse pass before a new command
  task automatic mst(input cmd_t c, input logic [7:0] d);
    int n;
    step;
    mst_cmd = c;
    mst_wdata = d;
    mst_cmd_valid = 1'b1;
    step;
    mst_cmd_valid = 1'b0;
    for (n = 0; n < 400 && mst_done !== 1'b1; n++) step;
    check("mst_done", mst_done, 1'b1);
    check("mst_ready", mst_ready, 1'b1);
  endtask : mst

  // ------------
  // Scenarios
  // ------------
  task automatic t_write;
    host_req(1'b1, 16'h0512, 32'ha1b2c3d4);
    check("nack", resp_nack, 1'b0);
    check("commits", wr_count, 1);
    check("reg_addr", wr_addr, 16'h0512);
    check("reg_data", wr_data, 32'ha1b2c3d4);
    wire_is('{8'h60, 8'h05, 8'h12, 8'hd4, 8'hc3, 8'hb2, 8'ha1});
  endtask : t_write
  // Issued in the response cycle of the write: back to back
  task automatic t_read;
    host_req(1'b0, 16'h0a5c, 32'h0);
    check("rdata", resp_rdata, 32'hf5a30a5c);
    check("rd_strobes", rd_count, 1);
    check("commits", wr_count, 1);
    wire_is('{8'h60, 8'h0a, 8'h5c, 8'h61, 8'h5c, 8'h0a, 8'ha3, 8'hf5});
  endtask : t_read
  // Foreign address, then a read with no register address before it
  task automatic t_refused;
    mst(CMD_START, 8'h00);
    mst(CMD_WRITE, 8'h62);
    check("foreign_ack", mst_ack_seen, 1'b0);
    mst(CMD_STOP, 8'h00);
    mst(CMD_START, 8'h00);
    mst(CMD_WRITE, {DEV_ADDR, 1'b1});
    check("bare_read_ack", mst_ack_seen, 1'b0);
    check("bare_read_strobe", rd_count, 1);
    mst(CMD_STOP, 8'h00);
    wb.delete();
    wa.delete();
  endtask : t_refused
  // Single data byte write, cut short: acked but never committed
  task automatic t_short;
    logic [7:0] b[4];
    b = '{8'h60, 8'h05, 8'h12, 8'h77};
    mst(CMD_START, 8'h00);
    foreach (b[i]) begin
      mst(CMD_WRITE, b[i]);
      check("ack", mst_ack_seen, 1'b1);
    end
    mst(CMD_STOP, 8'h00);
    check("commits", wr_count, 1);
    wire_is('{8'h60, 8'h05, 8'h12, 8'h77});
  endtask : t_short
  // Device master reads its own port back: receive path and our acks
  task automatic t_self_read;
    mst(CMD_START, 8'h00);
    mst(CMD_WRITE, 8'h60);
    mst(CMD_WRITE, 8'h01);
    mst(CMD_WRITE, 8'h2c);
    mst(CMD_START, 8'h00);
    mst(CMD_WRITE, 8'h61);
    check("self_addr_ack", mst_ack_seen, 1'b1);
    mst(CMD_READ, 8'h00);
    check("self_b0", mst_rdata, 8'h2c);
    mst(CMD_READ, 8'h00);
    check("self_b1", mst_rdata, 8'h01);
    mst(CMD_READ, 8'h00);
    check("self_b2", mst_rdata, 8'hd3);
    mst(CMD_READ, 8'h00);
    check("self_b3", mst_rdata, 8'hfe);
    mst(CMD_STOP, 8'h00);
    check("rd_strobes", rd_count, 2);
    wire_is('{8'h60, 8'h01, 8'h2c, 8'h61, 8'h2c, 8'h01, 8'hd3, 8'hfe});
  endtask : t_self_read

  task automatic results;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // Main sequence; device needs a quiet microsecond after reset
  initial begin
    repeat (12) step;
    reset_n = 1'b1;
    repeat (20) step;
    t_write;
    t_read;
    t_refused;
    t_short;
    t_self_read;
    results;
  end
  // Watchdog, several times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    results;
  end
endmodule : i2c_page_mode_register_port_tb
